//--- common/bfa_pkg.sv
// *****************************************************************
// Constants shared by the bridge fault action block
// *****************************************************************
package bfa_pkg;

    // Widths and counts
    localparam int DW    = 32;
    localparam int AW    = 8;
    localparam int NFET  = 4;   // 0 low A, 1 high A, 2 low B, 3 high B
    localparam int QTW   = 6;
    localparam int NMISC = 4;
    localparam int NVER  = 4;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_CONFIG = 8'h00;
    localparam logic [AW-1:0] OFS_MASK   = 8'h04;
    localparam logic [AW-1:0] OFS_DIAG1  = 8'h08;
    localparam logic [AW-1:0] OFS_DIAG2  = 8'h0c;
    localparam logic [AW-1:0] OFS_STATUS = 8'h10;
    localparam logic [AW-1:0] OFS_STATE  = 8'h14;
    localparam logic [AW-1:0] OFS_VERIFY = 8'h18;

    // Configuration fields
    localparam int CFG_ESF_BIT = 0;
    localparam int CFG_EWD_BIT = 1;
    localparam int CFG_VDQ_BIT = 2;
    localparam int CFG_QT_LSB  = 8;

    // Mask fields
    localparam int MSK_VDS_BIT  = 0;
    localparam int MSK_BOOT_BIT = 1;
    localparam int MSK_VREG_BIT = 2;
    localparam int MSK_LOGIC_BIT = 3;
    localparam int MSK_WD_BIT   = 4;
    localparam int MSK_MISC_LSB = 8;

    // Status fields
    localparam int ST_VREG_BIT  = 0;
    localparam int ST_LOGIC_BIT = 1;
    localparam int ST_OT_BIT    = 2;
    localparam int ST_WD_BIT    = 3;
    localparam int ST_STX_BIT   = 4;
    localparam int ST_MISC_LSB  = 8;

    // Values after reset
    localparam logic [DW-1:0]   CONFIG_RST = 32'h0000_1000;
    localparam logic [DW-1:0]   MASK_RST   = 32'h0000_0000;
    localparam logic [NVER-1:0] VERIFY_RST = 4'h0;

    // Timing: one qualify step is 100 ns
    localparam int CLK_NS     = 10;
    localparam int QT_STEP_NS = 100;
    localparam int TICK_CYC   = (QT_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_CW    = 4;

    // AHB-Lite codes
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [0:0] {
        BFA_BUS_IDLE   = 1'b0,
        BFA_BUS_RDWAIT = 1'b1
    } bfa_bus_t;

endpackage

//--- common/bfa_qual_if.sv
`timescale 1ns/100ps
// *****************************************************************
// Link between the fault logic and one overvoltage qualifier
// *****************************************************************
interface bfa_qual_if;
    logic                   cmp;
    logic                   gate_on;
    logic                   tick;
    logic                   blank_mode;
    logic [bfa_pkg::QTW-1:0] qual_time;
    logic                   valid;

    modport ctrl (output cmp, gate_on, tick, blank_mode, qual_time,
                  input valid);
    modport qual (input cmp, gate_on, tick, blank_mode, qual_time,
                  output valid);
endinterface

//--- src/bfa_sync.sv
`timescale 1ns/100ps
// *****************************************************************
// Two-stage synchroniser for pin inputs
// *****************************************************************
module bfa_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

//--- src/bfa_vds_qual.sv
`timescale 1ns/100ps
// *****************************************************************
// Overvoltage qualifier for one MOSFET: debounce or blanking
// *****************************************************************
module bfa_vds_qual
    import bfa_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    bfa_qual_if.qual  q
);
    logic [QTW-1:0] cnt_reg;
    logic [QTW-1:0] cnt_next;
    logic           on_d_reg;

    wire on_rise = q.gate_on & ~on_d_reg;
    wire active  = q.cmp & q.gate_on;
    wire at_end  = (cnt_reg >= q.qual_time);
    wire step    = q.tick & ~at_end;

    // Debounce restarts on a quiet comparator; blanking on turn-on
    always_comb begin
        cnt_next = cnt_reg;
        if (q.blank_mode) begin
            if (on_rise)
                cnt_next = '0;
            else if (step)
                cnt_next = cnt_reg + 1'b1;
        end else begin
            if (!active)
                cnt_next = '0;
            else if (step)
                cnt_next = cnt_reg + 1'b1;
        end
    end

    // Fault valid once the qualify time has run out
    assign q.valid = active & at_end & ~on_rise;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            on_d_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            on_d_reg <= q.gate_on;
        end
    end
endmodule

//--- src/bfa_fault_action.sv
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - Low-side overvoltage sets its diagnostic bit and switches that MOSFET off.
// - High-side overvoltage sets its diagnostic bit and switches that MOSFET off.
// - Blanking mode ignores the comparator for qualify time after turn-on.
// - With stop-all set, a short fault switches off every MOSFET.
// - Power-on reset or regulator undervoltage holds all gates low, unlatched.
// - Enabled watchdog timeout holds all gates low until the watchdog restarts.
// - Logic overvoltage or overtemperature stops all gates only when stop-all set.
// - Overvoltage or bootstrap fault with stop-all latches and stops all gates.
// - Without stop-all, only the faulty MOSFET stops; next on-command clears.
// - Latched states clear on clear pin low, power-on reset, or bit read.
// - Fault bits clear only on power-on reset or read, not clear pin.
// - Non-latching faults act only while the condition is detected.
// - Other faults leave the gate outputs enabled.
// - A set mask bit disables that diagnostic completely.
// - Power-on reset, serial error and overtemperature cannot be masked.
// - Off-line verification runs only when the controller commands it.
// - A valid overvoltage fault also raises the general fault flag.
// - Debounce timer runs while fault shows, restarts on return, 100 ns steps.
module bfa_fault_action
    import bfa_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [bfa_pkg::DW-1:0] hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic      [bfa_pkg::DW-1:0] hrdata,
    output logic                       hresp,
    // Detector and controller pins
    input  wire logic [bfa_pkg::NFET-1:0] vds_cmp,
    input  wire logic [bfa_pkg::NFET-1:0] boot_uv,
    input  wire logic [bfa_pkg::NFET-1:0] gate_cmd,
    input  wire logic                  fault_clear_n,
    input  wire logic                  vreg_uv,
    input  wire logic                  logic_ov,
    input  wire logic                  overtemp,
    input  wire logic                  wd_timeout,
    input  wire logic                  serial_err,
    input  wire logic [bfa_pkg::NMISC-1:0] misc_fault,
    // Gate drive and flags
    output logic      [bfa_pkg::NFET-1:0] gate_out,
    output logic                       fault_flag,
    output logic      [bfa_pkg::NVER-1:0] verify_run
);
    import bfa_pkg::*;

    // *************************************************************
    // Pin synchronisation
    // *************************************************************
    localparam int NPIN = 3 * NFET + 6 + NMISC;

    logic [NPIN-1:0]  pins_s;
    logic [NFET-1:0]  cmp_s;
    logic [NFET-1:0]  boot_s;
    logic [NFET-1:0]  cmd_s;
    logic             fclr_n_s;
    logic             vreg_s;
    logic             logic_s;
    logic             ot_s;
    logic             wd_s;
    logic             stx_s;
    logic [NMISC-1:0] misc_s;

    bfa_sync #(.W(NPIN)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   ({vds_cmp, boot_uv, gate_cmd, fault_clear_n, vreg_uv,
                 logic_ov, overtemp, wd_timeout, serial_err, misc_fault}),
        .dout  (pins_s)
    );

    // Split the synchronised bundle
    assign {cmp_s, boot_s, cmd_s, fclr_n_s, vreg_s, logic_s, ot_s, wd_s,
            stx_s, misc_s} = pins_s;

    // *************************************************************
    // Registers and bus state
    // *************************************************************
    logic [DW-1:0]    config_reg;
    logic [DW-1:0]    mask_reg;
    logic [NVER-1:0]  verify_reg;
    logic [NFET-1:0]  diag1_reg;
    logic [NFET-1:0]  diag2_reg;
    logic [DW-1:0]    status_reg;
    logic [NFET-1:0]  vds_lat_reg;
    logic [NFET-1:0]  boot_lat_reg;
    logic [NFET-1:0]  cmd_d_reg;
    logic [TICK_CW-1:0] tick_cnt_reg;
    bfa_bus_t         bus_reg;
    logic [AW-1:0]    rd_addr_reg;
    logic [AW-1:0]    wr_addr_reg;
    logic             wr_pend_reg;

    // Configuration fields
    wire stop_all_on_fault     = config_reg[CFG_ESF_BIT];
    wire enable_watchdog_on    = config_reg[CFG_EWD_BIT];
    wire qualifier_mode_select = config_reg[CFG_VDQ_BIT];
    wire [QTW-1:0] qualify_time = config_reg[CFG_QT_LSB +: QTW];

    // *************************************************************
    // Qualify step divider
    // *************************************************************
    wire tick_100ns = (tick_cnt_reg == TICK_CW'(TICK_CYC - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_100ns ? '0 : tick_cnt_reg + 1'b1;
    end

    // *************************************************************
    // Overvoltage qualifiers, one per MOSFET
    // *************************************************************
    logic [NFET-1:0] vds_valid;

    generate
        for (genvar i = 0; i < NFET; i++) begin : g_qual
            bfa_qual_if qif ();
            assign qif.cmp        = cmp_s[i];
            assign qif.gate_on    = cmd_s[i];
            assign qif.tick       = tick_100ns;
            assign qif.blank_mode = qualifier_mode_select;
            assign qif.qual_time  = qualify_time;
            assign vds_valid[i]   = qif.valid;

            bfa_vds_qual u_qual (
                .mclk  (mclk),
                .rst_n (rst_n),
                .q     (qif.qual)
            );
        end
    endgenerate

    // *************************************************************
    // Masked diagnostics
    // *************************************************************
    wire [NFET-1:0] vds_ok  = vds_valid & {NFET{~mask_reg[MSK_VDS_BIT]}};
    wire [NFET-1:0] boot_ok = boot_s & {NFET{~mask_reg[MSK_BOOT_BIT]}};
    wire vreg_ok  = vreg_s & ~mask_reg[MSK_VREG_BIT];
    wire logic_ok = logic_s & ~mask_reg[MSK_LOGIC_BIT];
    wire wd_ok    = wd_s & enable_watchdog_on & ~mask_reg[MSK_WD_BIT];
    wire ot_ok    = ot_s;
    wire stx_ok   = stx_s;
    wire [NMISC-1:0] misc_ok = misc_s & ~mask_reg[MSK_MISC_LSB +: NMISC];

    // *************************************************************
    // Bus decode
    // *************************************************************
    wire bus_take  = hsel & hready & htrans[1];
    wire rd_take   = bus_take & ~hwrite;
    wire wr_take   = bus_take & hwrite & (hsize == HSIZE_WORD);
    wire rd_wait   = (bus_reg == BFA_BUS_RDWAIT);
    wire clr_diag1 = rd_wait & (rd_addr_reg == OFS_DIAG1);
    wire clr_diag2 = rd_wait & (rd_addr_reg == OFS_DIAG2);
    wire clr_stat  = rd_wait & (rd_addr_reg == OFS_STATUS);
    wire wr_config = wr_pend_reg & (wr_addr_reg == OFS_CONFIG);
    wire wr_mask   = wr_pend_reg & (wr_addr_reg == OFS_MASK);
    wire wr_verify = wr_pend_reg & (wr_addr_reg == OFS_VERIFY);

    // *************************************************************
    // Latched fault states
    // *************************************************************
    wire [NFET-1:0] cmd_rise = cmd_s & ~cmd_d_reg;
    wire [NFET-1:0] on_clr   = cmd_rise & {NFET{~stop_all_on_fault}};
    wire [NFET-1:0] vds_clr  = {NFET{clr_diag1 | ~fclr_n_s}} | on_clr;
    wire [NFET-1:0] boot_clr = {NFET{clr_diag2 | ~fclr_n_s}} | on_clr;

    // Set wins over clear; reset comes from power-on
    wire [NFET-1:0] vds_lat_next  = (vds_lat_reg & ~vds_clr) | vds_ok;
    wire [NFET-1:0] boot_lat_next = (boot_lat_reg & ~boot_clr) | boot_ok;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vds_lat_reg  <= '0;
            boot_lat_reg <= '0;
            cmd_d_reg    <= '0;
        end else begin
            vds_lat_reg  <= vds_lat_next;
            boot_lat_reg <= boot_lat_next;
            cmd_d_reg    <= cmd_s;
        end
    end

    // *************************************************************
    // Gate disable decision
    // *************************************************************
    wire [NFET-1:0] short_act = vds_ok | vds_lat_reg;
    wire [NFET-1:0] fet_act   = short_act | boot_ok | boot_lat_reg;
    wire stop_crit  = vreg_ok | wd_ok;
    wire stop_esf   = stop_all_on_fault &
                      (logic_ok | ot_ok | (|fet_act));
    wire all_off    = stop_crit | stop_esf;
    wire [NFET-1:0] gate_next = cmd_s & ~fet_act &
                                {NFET{~all_off}};
    wire flag_next  = (|fet_act) | stop_crit | logic_ok | ot_ok;

    // Gates are low under reset and follow live faults
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_out   <= '0;
            fault_flag <= 1'b0;
        end else begin
            gate_out   <= gate_next;
            fault_flag <= flag_next;
        end
    end

    // *************************************************************
    // Sticky diagnostic and status bits
    // *************************************************************
    logic [DW-1:0] stat_set;

    always_comb begin
        stat_set = '0;
        stat_set[ST_VREG_BIT]  = vreg_ok;
        stat_set[ST_LOGIC_BIT] = logic_ok;
        stat_set[ST_OT_BIT]    = ot_ok;
        stat_set[ST_WD_BIT]    = wd_ok;
        stat_set[ST_STX_BIT]   = stx_ok;
        stat_set[ST_MISC_LSB +: NMISC] = misc_ok;
    end

    // Cleared by read or power-on reset only; clear pin does not reach them
    wire [NFET-1:0] diag1_next = (diag1_reg & ~{NFET{clr_diag1}}) | vds_ok;
    wire [NFET-1:0] diag2_next = (diag2_reg & ~{NFET{clr_diag2}}) | boot_ok;
    wire [DW-1:0]   stat_next  = (status_reg & ~{DW{clr_stat}}) | stat_set;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            diag1_reg  <= '0;
            diag2_reg  <= '0;
            status_reg <= '0;
        end else begin
            diag1_reg  <= diag1_next;
            diag2_reg  <= diag2_next;
            status_reg <= stat_next;
        end
    end

    // *************************************************************
    // Software registers
    // *************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= CONFIG_RST;
            mask_reg   <= MASK_RST;
            verify_reg <= VERIFY_RST;
        end else begin
            if (wr_config)
                config_reg <= hwdata;
            if (wr_mask)
                mask_reg <= hwdata;
            if (wr_verify)
                verify_reg <= hwdata[NVER-1:0];
        end
    end

    // Off-line checks run only while software holds them on
    assign verify_run = verify_reg;

    // *************************************************************
    // Read mux
    // *************************************************************
    logic [DW-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (rd_addr_reg)
            OFS_CONFIG: rd_mux = config_reg;
            OFS_MASK:   rd_mux = mask_reg;
            OFS_DIAG1:  rd_mux[NFET-1:0] = diag1_reg;
            OFS_DIAG2:  rd_mux[NFET-1:0] = diag2_reg;
            OFS_STATUS: rd_mux = status_reg;
            OFS_STATE:  rd_mux[3*NFET+1:0] = {fault_flag, all_off,
                            boot_lat_reg, vds_lat_reg, gate_out};
            OFS_VERIFY: rd_mux[NVER-1:0] = verify_reg;
            default:    rd_mux = '0;
        endcase
    end

    // *************************************************************
    // AHB-Lite slave: reads take one wait state, writes none
    // *************************************************************
    assign hreadyout = ~rd_wait;
    assign hresp     = 1'b0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_reg     <= BFA_BUS_IDLE;
            rd_addr_reg <= '0;
            wr_addr_reg <= '0;
            wr_pend_reg <= 1'b0;
            hrdata      <= '0;
        end else begin
            wr_pend_reg <= wr_take;
            if (wr_take)
                wr_addr_reg <= haddr[AW-1:0];
            unique case (bus_reg)
                BFA_BUS_IDLE: begin
                    if (rd_take) begin
                        rd_addr_reg <= haddr[AW-1:0];
                        bus_reg     <= BFA_BUS_RDWAIT;
                    end
                end
                BFA_BUS_RDWAIT: begin
                    hrdata  <= rd_mux;
                    bus_reg <= BFA_BUS_IDLE;
                end
            endcase
        end
    end
endmodule

//--- verification/bfa_fault_action_properties.sv
`timescale 1ns/100ps
// ****************************************************
// Port checker for the fault action block
// ****************************************************
module bfa_fault_action_props
    import bfa_pkg::*;
(
    input wire logic                     mclk,
    input wire logic                     rst_n,
    input wire logic                     hsel,
    input wire logic [31:0]              haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [2:0]               hsize,
    input wire logic [bfa_pkg::DW-1:0]   hwdata,
    input wire logic                     hready,
    input wire logic                     hreadyout,
    input wire logic                     hresp,
    input wire logic [bfa_pkg::NFET-1:0] vds_cmp,
    input wire logic [bfa_pkg::NFET-1:0] boot_uv,
    input wire logic [bfa_pkg::NFET-1:0] gate_cmd,
    input wire logic                     vreg_uv,
    input wire logic                     overtemp,
    input wire logic                     wd_timeout,
    input wire logic [bfa_pkg::NFET-1:0] gate_out,
    input wire logic                     fault_flag
);
    logic          wr_ph;
    logic [AW-1:0] wa;
    logic [DW-1:0] cfg;
    logic [DW-1:0] msk;
    // Zero qualify time in debounce mode
    wire qt0 = cfg[CFG_QT_LSB+:QTW] == 6'h00 && !cfg[CFG_VDQ_BIT];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow of config and mask writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ph <= 1'b0;
            wa    <= 8'h00;
            cfg   <= CONFIG_RST;
            msk   <= MASK_RST;
        end else if (hready) begin
            wr_ph <= hsel && htrans[1] && hwrite && hsize == HSIZE_WORD;
            wa    <= haddr[AW-1:0];
            if (wr_ph && wa == OFS_CONFIG) cfg <= hwdata;
            if (wr_ph && wa == OFS_MASK) msk <= hwdata;
        end
    end
    sequence s_rd_req; hsel && hready && htrans[1] && !hwrite; endsequence
    sequence s_wr_req; hsel && hready && htrans[1] && hwrite; endsequence
    property p_okay; hresp == 1'b0; endproperty
    property p_rd_wait; s_rd_req |=> !hreadyout ##1 hreadyout; endproperty
    property p_wr_ready; s_wr_req |=> hreadyout; endproperty
    property p_vreg_off;
        (!msk[MSK_VREG_BIT] && vreg_uv)[*3] |=> gate_out == 4'h0;
    endproperty
    property p_wd_off;
        (cfg[CFG_EWD_BIT] && !msk[MSK_WD_BIT] && wd_timeout)[*3]
            |=> gate_out == 4'h0;
    endproperty
    property p_ot_stop; (cfg[CFG_ESF_BIT] && overtemp)[*3] |=> !gate_out;
    endproperty
    property p_ot_flag; overtemp[*3] |=> fault_flag; endproperty
    a_okay: assert property (p_okay) else $error("hresp not OKAY");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
    a_vreg_off: assert property (p_vreg_off)
        else $error("gates on in vreg fault");
    a_wd_off: assert property (p_wd_off)
        else $error("gates on in watchdog fault");
    a_ot_stop: assert property (p_ot_stop)
        else $error("gates on in overtemp");
    a_ot_flag: assert property (p_ot_flag)
        else $error("overtemp raised no flag");
    // Per MOSFET overvoltage reaction
    for (genvar i = 0; i < NFET; i++) begin : g_fet
        sequence s_vds_seen;
            (qt0 && !msk[MSK_VDS_BIT] && vds_cmp[i] && gate_cmd[i])[*3];
        endsequence
        property p_vds_off;
            s_vds_seen |=> fault_flag &&
                (cfg[CFG_ESF_BIT] ? gate_out == 4'h0 : !gate_out[i]);
        endproperty
        property p_vds_masked;
            (msk[MSK_VDS_BIT] && !cfg[CFG_ESF_BIT] && gate_cmd[i] &&
             !boot_uv[i] && !vreg_uv && !wd_timeout)[*5] |=> gate_out[i];
        endproperty
        a_vds_off: assert property (p_vds_off)
            else $error("overvoltage gate not off");
        a_vds_masked: assert property (p_vds_masked)
            else $error("masked fault stopped gate");
    end
endmodule

bind bfa_fault_action bfa_fault_action_props i_bfa_fault_action_props (
    .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .vds_cmp, .boot_uv, .gate_cmd, .vreg_uv,
    .overtemp, .wd_timeout, .gate_out, .fault_flag
);

//--- verification/bfa_ctrl_model.sv
`timescale 1ns/100ps
// ****************************************************
// Controller side: gate commands and clear pin
// ****************************************************
module bfa_ctrl_model (
    input  wire logic       mclk,
    input  wire logic [3:0] cmd_req,
    input  wire logic       clr_req,
    output logic      [3:0] gate_cmd = 4'h0,
    output logic            fault_clear_n = 1'b1
);
    // Pins change just after each edge
    always @(posedge mclk) begin
        gate_cmd      <= cmd_req;
        fault_clear_n <= !clr_req;
    end
endmodule

//--- verification/bfa_fault_action_tb.sv
`timescale 1ns/100ps
// ****************************************************
// Bench for the bridge fault action block
// ****************************************************
module bfa_fault_action_tb;
    import bfa_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, r;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  vds = 4'h0, boot = 4'h0, cmd = 4'h0, misc = 4'h0;
    logic        clr = 1'b0, vreg = 1'b0, lov = 1'b0, ot = 1'b0;
    logic        wd = 1'b0, serr = 1'b0;
    wire         hready, hresp, fault_clear_n, fault_flag;
    wire  [31:0] hrdata;
    wire  [3:0]  gate_cmd, gate_out, verify_run;
    int          errors = 0, total_checks = 0;
    bfa_ctrl_model i_bfa_ctrl_model (.mclk, .cmd_req(cmd), .clr_req(clr),
        .gate_cmd, .fault_clear_n);
    bfa_fault_action i_bfa_fault_action (.mclk, .rst_n, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready),
        .hrdata, .hresp, .vds_cmp(vds), .boot_uv(boot), .gate_cmd,
        .fault_clear_n, .vreg_uv(vreg), .logic_ov(lov), .overtemp(ot),
        .wd_timeout(wd), .serial_err(serr), .misc_fault(misc), .gate_out,
        .fault_flag, .verify_run);
    initial begin
        forever #5 mclk = ~mclk;
    end
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(string n, logic [31:0] x, logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task cyc(int n);
        repeat (n) @(posedge mclk);
    endtask
    // Wait for hready sampled high at a rising edge
    task rdy;
        int n;
        n = 0;
        do @(posedge mclk); while (hready !== 1'b1 && ++n < 50);
        if (hready !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task bus(logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask
    task rdc(logic [7:0] a, logic [31:0] x);
        bus(1'b0, a, '0);
        chk("hrdata", x, r);
    endtask
    task gchk(logic [3:0] x);
        chk("gate_out", {28'h0, x}, {28'h0, gate_out});
    endtask
    task pulse_clr;
        clr <= 1'b1;
        cyc(2);
        clr <= 1'b0;
        cyc(6);
    endtask
    task vpulse(logic [3:0] v, int n);
        vds <= v;
        cyc(n);
        vds <= 4'h0;
    endtask
    // Drive fault pin k, all others low; k of 4 drives serial error and all misc pins
    task set_pin(int k, logic v);
        {lov, ot, wd, vreg} <= v ? 4'(1 << k) : 4'h0;
        {serr, misc} <= {5{v && k > 3}};
    endtask
    task t_pin(int k, logic [31:0] c, logic [3:0] x);
        bus(1'b1, OFS_CONFIG, c);
        set_pin(k, 1'b1);
        cyc(6);
        gchk(x);
        set_pin(k, 1'b0);
        cyc(6);
        gchk(4'hf);
    endtask
    task t_regs;
        rdc(OFS_CONFIG, CONFIG_RST);
        rdc(OFS_MASK, MASK_RST);
        rdc(8'h1c, 32'h0);
        bus(1'b1, OFS_VERIFY, 32'h5);
        cyc(1);
        chk("verify_run", 32'h5, {28'h0, verify_run});
        bus(1'b1, OFS_VERIFY, 32'h0);
    endtask
    task t_vds_local;
        bus(1'b1, OFS_CONFIG, 32'h0);
        cmd <= 4'hf;
        cyc(6);
        for (int i = 0; i < 4; i++) begin
            vpulse(4'h1 << i, 5);
            cyc(3);
            gchk(~(4'h1 << i));
            chk("fault_flag", 32'h1, {31'h0, fault_flag});
            pulse_clr();
            gchk(4'hf);
        end
        rdc(OFS_DIAG1, 32'hf);
        rdc(OFS_DIAG1, 32'h0);
        vpulse(4'h1, 5);
        cmd <= 4'he;
        cyc(5);
        cmd <= 4'hf;
        cyc(6);
        gchk(4'hf);
        rdc(OFS_DIAG1, 32'h1);
    endtask
    task t_esf;
        bus(1'b1, OFS_CONFIG, 32'h1);
        vpulse(4'h8, 5);
        cyc(8);
        gchk(4'h0);
        rdc(OFS_DIAG1, 32'h8);
        cyc(4);
        gchk(4'hf);
        boot <= 4'h2;
        cyc(5);
        boot <= 4'h0;
        cyc(8);
        gchk(4'h0);
        pulse_clr();
        gchk(4'hf);
        rdc(OFS_DIAG2, 32'h2);
    endtask
    task t_qual;
        bus(1'b1, OFS_CONFIG, 32'h0200);
        vpulse(4'h1, 5);
        cyc(6);
        gchk(4'hf);
        vds <= 4'h1;
        cyc(30);
        gchk(4'he);
        vds <= 4'h0;
        rdc(OFS_DIAG1, 32'h1);
        bus(1'b1, OFS_CONFIG, 32'h0204);
        cmd <= 4'he;
        vds <= 4'h1;
        cyc(6);
        cmd <= 4'hf;
        cyc(8);
        gchk(4'hf);
        cyc(30);
        gchk(4'he);
        vds <= 4'h0;
        rdc(OFS_DIAG1, 32'h1);
    endtask
    task t_mask;
        bus(1'b1, OFS_MASK, 32'hfff);
        t_pin(2, 32'h1, 4'h0);
        t_pin(0, 32'h0, 4'hf);
        vpulse(4'h1, 8);
        gchk(4'hf);
        rdc(OFS_DIAG1, 32'h0);
        bus(1'b1, OFS_MASK, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_vds_local();
        t_esf();
        t_pin(0, 32'h0, 4'h0);
        t_pin(1, 32'h2, 4'h0);
        t_pin(2, 32'h0, 4'hf);
        t_pin(2, 32'h1, 4'h0);
        t_pin(3, 32'h1, 4'h0);
        t_pin(4, 32'h1, 4'hf);
        rdc(OFS_STATUS, 32'h0f1f);
        rdc(OFS_STATUS, 32'h0);
        t_mask();
        t_qual();
        tally_and_finish();
    end
endmodule
